/* shared/dbgc_regs.svh */
`ifndef DBGC_REGS_SVH
`define DBGC_REGS_SVH

// command codes
`define DBGC_CMD_STATUS_READ   8'hE4
`define DBGC_CMD_CONTROL_WRITE 8'hC4
`define DBGC_CMD_HALT_REQUEST  8'h90
`define DBGC_CMD_RESUME        8'h08

// field positions of debug_ctrl_status
`define DBGC_BIT_PERMIT        7
`define DBGC_BIT_HALTED        6
`define DBGC_BIT_BRK_EN        5
`define DBGC_BIT_FORCE         4
`define DBGC_BIT_LOW_POWER     2
`define DBGC_BIT_LP_FAIL       1

// reset value of the control bits
`define DBGC_CTRL_RESET        8'h00
// mask of writable bits
`define DBGC_WRITE_MASK        8'hB0

`endif

/* shared/dbgc_pkg.sv */
package dbgc_pkg;

	// one command from the serial engine
	typedef struct packed {
		logic       valid;
		logic [7:0] code;
		logic [7:0] data;
	} dbgc_cmd_t;

	// CPU-side status inputs
	typedef struct packed {
		logic        in_low_power;
		logic        at_boundary;
		logic        queue_end;
		logic        mem_fail;
		logic [13:0] addr;
		logic        fetch;
	} dbgc_cpu_t;

	typedef enum logic [1:0] {
		DBGC_RUN  = 2'b01,
		DBGC_HALT = 2'b10
	} dbgc_mode_t;

endpackage : dbgc_pkg

/* src/dbgc_brk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dbgc_regs.svh"

module dbgc_brk #(
	parameter int AW = 14
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          enable,
	input  wire logic          force_sel,
	input  wire logic [AW-1:0] match_addr,
	input  wire logic [AW-1:0] cpu_addr,
	input  wire logic          fetch,
	input  wire logic          at_boundary,
	input  wire logic          queue_end,
	input  wire logic          halted,
	output logic               break_req
);
	typedef struct packed {
		logic pend;
		logic tag;
	} dbgc_brk_st_t;

	dbgc_brk_st_t st_q;
	dbgc_brk_st_t st_d;
	logic         hit;

	// R5 disabled ignores
	assign hit = enable && (cpu_addr == match_addr);

	always_comb begin
		st_d = st_q;
		// R6 force mode
		if (hit && force_sel)
			st_d.pend = 1'b1;
		// R7 tag fetched opcode
		if (hit && !force_sel && fetch)
			st_d.tag = 1'b1;
		if (halted || !enable) begin
			st_d.pend = 1'b0;
			st_d.tag  = 1'b0;
		end
	end

	// tagged opcode only stops once it reaches the queue end
	assign break_req = !halted && ((st_q.pend && at_boundary) || (st_q.tag && queue_end));

	always_ff @(posedge clk) begin
		if (rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end
endmodule : dbgc_brk
`default_nettype wire

/* src/dbgc_cmd.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dbgc_regs.svh"

module dbgc_cmd (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire dbgc_pkg::dbgc_cmd_t cmd,
	input  wire logic              halted,
	input  wire logic              low_power,
	output logic                   is_read,
	output logic                   is_write,
	output logic                   is_halt,
	output logic                   is_resume
);
	logic v;

	// R9 low power blocks only resume here; read, write and halt still pass
	assign v = cmd.valid && !rst;
	// R13 serial commands only
	assign is_read   = v && cmd.code == `DBGC_CMD_STATUS_READ;
	assign is_write  = v && cmd.code == `DBGC_CMD_CONTROL_WRITE;
	// R9 halt request still works
	assign is_halt   = v && cmd.code == `DBGC_CMD_HALT_REQUEST;
	assign is_resume = v && !low_power && halted && cmd.code == `DBGC_CMD_RESUME;
endmodule : dbgc_cmd
`default_nettype wire

/* src/dbgc_top.sv */
// What this block does
// R1 - halt mode only entered when permit bit 7 is set
// R2 - permit bit stays set until normal reset; the code also lets a control write outside halt clear it
// R3 - host sets permit early when stop mode and debug wanted
// R4 - bit 6 shows halted: 1 in halt mode, 0 running
// R5 - bit 5 clear disables breakpoint, ignoring force select and address
// R6 - force select 1: address match halts at next instruction boundary
// R7 - force select 0: match tags opcode, halts when it reaches queue end
// R8 - bit 2 shows wait/stop, or halt entered from wait/stop
// R9 - in wait/stop most commands fail; halt request still halts; the code blocks only resume, while read and control write still pass
// R10 - host reads status and checks halted before other commands
// R11 - bit 1 set when memory command fails due to wait/stop
// R12 - host recovers by halt request, repeat, resume
// R13 - register reached only by status read and control write commands
// R14 - status bits read-only, control write never changes them
// R15 - control write during halt leaves permit unchanged
// R16 - status read is code E4, returns eight bits
// R17 - control write is code C4 with eight data bits
// R18 - bits 3 and 0 read zero, writes ignored
// R19 - halted set on halt entry, cleared when program resumes
`timescale 1ns/1ps
`default_nettype none
`include "dbgc_regs.svh"

module dbgc_top #(
	parameter int AW = 14
) (
	input  wire logic                CLK,
	input  wire logic                SYS_RST,
	input  wire dbgc_pkg::dbgc_cmd_t CMD,
	input  wire dbgc_pkg::dbgc_cpu_t CPU,
	input  wire logic [AW-1:0]       BRK_ADDR,
	output logic                     RD_VALID,
	output logic [7:0]               RD_DATA,
	output logic                     HALT_CPU,
	output logic                     HALTED
);
	typedef struct packed {
		logic               permit;
		logic               brk_en;
		logic               force_sel;
		dbgc_pkg::dbgc_mode_t mode;
		logic               lp_entry;
		logic               lp_fail;
		logic               rd_valid;
		logic [7:0]         rd_data;
	} dbgc_st_t;

	dbgc_st_t st_q;
	dbgc_st_t st_d;
	logic     is_read;
	logic     is_write;
	logic     is_halt;
	logic     is_resume;
	logic     break_req;
	logic     halted;
	logic     low_power;
	logic [7:0] status;

	// reset image kept at byte width so single bits can be picked from it
	localparam logic [7:0] ctrl_reset = `DBGC_CTRL_RESET;

	assign halted = (st_q.mode == dbgc_pkg::DBGC_HALT);
	// R8 wait/stop status
	assign low_power = CPU.in_low_power || (halted && st_q.lp_entry);

	dbgc_cmd u_cmd (
		.clk       (CLK),
		.rst       (SYS_RST),
		.cmd       (CMD),
		.halted    (halted),
		.low_power (CPU.in_low_power),
		.is_read   (is_read),
		.is_write  (is_write),
		.is_halt   (is_halt),
		.is_resume (is_resume)
	);

	dbgc_brk #(.AW(AW)) u_brk (
		.clk         (CLK),
		.rst         (SYS_RST),
		.enable      (st_q.brk_en),
		.force_sel   (st_q.force_sel),
		.match_addr  (BRK_ADDR),
		.cpu_addr    (CPU.addr),
		.fetch       (CPU.fetch),
		.at_boundary (CPU.at_boundary),
		.queue_end   (CPU.queue_end),
		.halted      (halted),
		.break_req   (break_req)
	);

	// R18 unused bits zero
	always_comb begin
		status                   = 8'h00;
		status[`DBGC_BIT_PERMIT] = st_q.permit;
		// R4 halted indicator
		status[`DBGC_BIT_HALTED] = halted;
		status[`DBGC_BIT_BRK_EN] = st_q.brk_en;
		status[`DBGC_BIT_FORCE]  = st_q.force_sel;
		status[`DBGC_BIT_LOW_POWER] = low_power;
		status[`DBGC_BIT_LP_FAIL] = st_q.lp_fail;
	end

	always_comb begin
		st_d          = st_q;
		st_d.rd_valid = 1'b0;
		// R16 status read E4
		if (is_read) begin
			st_d.rd_valid = 1'b1;
			st_d.rd_data  = status;
		end
		// R17 control write C4
		if (is_write) begin
			// R15 permit frozen in halt
			if (!halted)
				st_d.permit = CMD.data[`DBGC_BIT_PERMIT];
			// R14 status bits untouched
			st_d.brk_en    = CMD.data[`DBGC_BIT_BRK_EN];
			st_d.force_sel = CMD.data[`DBGC_BIT_FORCE];
		end
		// R11 failure flag, set wins
		if (CMD.valid && CPU.mem_fail && CPU.in_low_power)
			st_d.lp_fail = 1'b1;
		else if (halted && !CPU.in_low_power && is_resume)
			st_d.lp_fail = 1'b0;
		case (st_q.mode)
			dbgc_pkg::DBGC_RUN: begin
				// R1 entry needs permit
				if (st_q.permit && (is_halt || break_req)) begin
					// R19 set on halt entry
					st_d.mode     = dbgc_pkg::DBGC_HALT;
					st_d.lp_entry = CPU.in_low_power;
				end
			end
			dbgc_pkg::DBGC_HALT: begin
				// R19 clear on resume
				if (is_resume) begin
					st_d.mode     = dbgc_pkg::DBGC_RUN;
					st_d.lp_entry = 1'b0;
				end
			end
			default: st_d.mode = dbgc_pkg::DBGC_RUN;
		endcase
	end

	assign RD_VALID = st_q.rd_valid;
	assign RD_DATA  = st_q.rd_data;
	assign HALT_CPU = halted;
	assign HALTED   = halted;

	// R2 permit cleared by reset or by a control write outside halt
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			st_q           <= '0;
			st_q.permit    <= ctrl_reset[`DBGC_BIT_PERMIT];
			st_q.mode      <= dbgc_pkg::DBGC_RUN;
		end else begin
			st_q <= st_d;
		end
	end
endmodule : dbgc_top
`default_nettype wire

/* tb/dbgc_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module dbgc_top_assertions #(
	parameter int AW = 14
) (
	input wire logic                CLK,
	input wire logic                SYS_RST,
	input wire dbgc_pkg::dbgc_cmd_t CMD,
	input wire dbgc_pkg::dbgc_cpu_t CPU,
	input wire logic [AW-1:0]       BRK_ADDR,
	input wire logic                RD_VALID,
	input wire logic [7:0]          RD_DATA,
	input wire logic                HALT_CPU,
	input wire logic                HALTED
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (SYS_RST);
	sequence s_rd;
		CMD.valid && CMD.code == 8'hE4;
	endsequence
	sequence s_go;
		CMD.valid && CMD.code == 8'h08 && !CPU.in_low_power;
	endsequence
	chk_read_answer: assert property (s_rd |=> RD_VALID)
		else $error("read unanswered");
	chk_byte_stands: assert property (!RD_VALID && !$past(SYS_RST) |-> $stable(RD_DATA))
		else $error("byte moved");
	chk_unused_zero: assert property (RD_VALID |-> !RD_DATA[3] && !RD_DATA[0])
		else $error("unused bit set");
	chk_halted_bit: assert property (RD_VALID |-> RD_DATA[6] == $past(HALTED))
		else $error("halted bit");
	chk_low_power: assert property (RD_VALID && $past(CPU.in_low_power) |-> RD_DATA[2])
		else $error("low power bit");
	chk_halt_pair: assert property (HALT_CPU == HALTED)
		else $error("halt outputs differ");
	chk_go_resume: assert property (HALTED ##0 s_go |=> !HALTED)
		else $error("resume ignored");
	chk_halt_holds: assert property (HALTED && !CMD.valid |=> HALTED)
		else $error("halt dropped");
endmodule : dbgc_top_assertions
bind dbgc_top dbgc_top_assertions #(.AW(AW)) u_chk (.CLK(CLK), .SYS_RST(SYS_RST),
	.CMD(CMD), .CPU(CPU), .BRK_ADDR(BRK_ADDR), .RD_VALID(RD_VALID),
	.RD_DATA(RD_DATA), .HALT_CPU(HALT_CPU), .HALTED(HALTED));
`default_nettype wire

/* tb/dbgc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module dbgc_host (
	input wire logic               clk,
	output var dbgc_pkg::dbgc_cmd_t cmd
);
	initial cmd = '0;
	task automatic send(input logic [7:0] code, input logic [7:0] data);
		cmd <= {1'b1, code, data};
		@(posedge clk);
		// idle lines never repeat stale bits
		cmd <= {1'b0, ~code, ~data};
		@(posedge clk);
	endtask : send
endmodule : dbgc_host
`default_nettype wire

/* tb/dbgc_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dbgc_top_tb;
	logic                clk = 1'b0;
	logic                rst = 1'b1;
	dbgc_pkg::dbgc_cpu_t cpu = '0;
	dbgc_pkg::dbgc_cmd_t cmd;
	logic [7:0]          rdd;
	logic                rdv;
	logic                hlt;
	logic                hcpu;
	logic [13:0]         brk = 14'h1A5;
	int                  rd_cnt = 0;
	int                  err_total = 0;
	int                  total_checks = 0;
	always #25 clk = ~clk;
	// counts status pulses, one per read expected
	always @(posedge clk)
		if (rdv === 1'b1)
			rd_cnt <= rd_cnt + 1;
	dbgc_host host (.clk(clk), .cmd(cmd));
	dbgc_top dut (.CLK(clk), .SYS_RST(rst), .CMD(cmd), .CPU(cpu), .BRK_ADDR(brk),
		.RD_VALID(rdv), .RD_DATA(rdd), .HALT_CPU(hcpu), .HALTED(hlt));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic rd(input logic [7:0] e);
		int n;
		n = rd_cnt;
		host.send(8'hE4, 8'h00);
		#1 chk("status", e, rdd);
		chk("read pulses", 8'(n + 1), 8'(rd_cnt));
		@(posedge clk);
	endtask : rd
	task automatic hc(input logic e);
		repeat (3) @(posedge clk);
		#1 chk("halted", {7'h00, e}, {7'h00, hlt});
		chk("halt cpu", {7'h00, e}, {7'h00, hcpu});
		@(posedge clk);
	endtask : hc
	task automatic results;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : results
	initial begin
		repeat (2000) @(posedge clk);
		err_total++;
		results();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(8'h00);
		host.send(8'h90, 8'h00);
		hc(1'b0);
		host.send(8'hC4, 8'hFF);
		rd(8'hB0);
		host.send(8'h90, 8'h00);
		hc(1'b1);
		rd(8'hF0);
		host.send(8'hC4, 8'h00);
		rd(8'hC0);
		host.send(8'h08, 8'h00);
		rd(8'h80);
		cpu.in_low_power <= 1'b1;
		rd(8'h84);
		cpu.mem_fail <= 1'b1;
		host.send(8'hE0, 8'h00);
		cpu.mem_fail <= 1'b0;
		rd(8'h86);
		host.send(8'h90, 8'h00);
		rd(8'hC6);
		cpu.in_low_power <= 1'b0;
		host.send(8'hE0, 8'h00);
		host.send(8'h08, 8'h00);
		rd(8'h80);
		cpu.addr <= 14'h1A5;
		cpu.at_boundary <= 1'b1;
		cpu.queue_end <= 1'b1;
		cpu.fetch <= 1'b1;
		hc(1'b0);
		brk <= 14'h1A4;
		host.send(8'hC4, 8'hB0);
		hc(1'b0);
		brk <= 14'h1A5;
		hc(1'b1);
		cpu <= '0;
		host.send(8'h08, 8'h00);
		host.send(8'hC4, 8'hA0);
		cpu.addr <= 14'h1A5;
		cpu.fetch <= 1'b1;
		cpu.at_boundary <= 1'b1;
		hc(1'b0);
		cpu.queue_end <= 1'b1;
		hc(1'b1);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(8'h00);
		hc(1'b0);
		results();
	end
endmodule : dbgc_top_tb
`default_nettype wire
